/* File: common/sram_host_defs.svh */
// timing and width constants for the static ram access port controller
`ifndef SRAM_HOST_DEFS_SVH
`define SRAM_HOST_DEFS_SVH

`define SRAM_CLK_PERIOD_NS   25
`define SRAM_ADDR_W          15
`define SRAM_DATA_W          8
// address access delay, slowest grade, least time -> round up
`define SRAM_ADDR_ACCESS_NS  100
`define SRAM_ADDR_ACCESS_CYC ((`SRAM_ADDR_ACCESS_NS + `SRAM_CLK_PERIOD_NS - 1) / `SRAM_CLK_PERIOD_NS)
// two synchroniser stages sit in front of the read data
`define SRAM_SYNC_CYC        2
`define SRAM_READ_CYC        (`SRAM_ADDR_ACCESS_CYC + `SRAM_SYNC_CYC)
// write strobe pulse width
`define SRAM_WPULSE_NS       80
`define SRAM_WPULSE_CYC      ((`SRAM_WPULSE_NS + `SRAM_CLK_PERIOD_NS - 1) / `SRAM_CLK_PERIOD_NS)
// write data hold after the ending edge
`define SRAM_DHOLD_NS        5
`define SRAM_DHOLD_CYC       ((`SRAM_DHOLD_NS + `SRAM_CLK_PERIOD_NS - 1) / `SRAM_CLK_PERIOD_NS)
// strobe recovery before the next access
`define SRAM_WREC_NS         10
`define SRAM_WREC_CYC        ((`SRAM_WREC_NS + `SRAM_CLK_PERIOD_NS - 1) / `SRAM_CLK_PERIOD_NS)
// output release after chip select / output gate go high
`define SRAM_RREL_NS         50
`define SRAM_RREL_CYC        ((`SRAM_RREL_NS + `SRAM_CLK_PERIOD_NS - 1) / `SRAM_CLK_PERIOD_NS)

`endif

/* File: common/sram_host_pkg.sv */
// types for the static ram access port controller
`default_nettype none
package sram_host_pkg;
    typedef enum logic [5:0] {
        st_idle  = 6'h01,
        st_read  = 6'h02,
        st_write = 6'h04,
        st_whold = 6'h08,
        st_turn  = 6'h10,
        st_pfail = 6'h20
    } state_t;
endpackage
`default_nettype wire

/* File: rtl/async_sram_access_port.sv */
// host controller that drives an asynchronous byte-wide static ram
`include "sram_host_defs.svh"
`default_nettype none
module async_sram_access_port #(
    parameter int unsigned RECOVERY_CYC = 4000
) (
    input  wire logic                      clk_in,
    input  wire logic                      resetn_in,
    input  wire logic                      req_in,
    input  wire logic                      we_in,
    input  wire logic [`SRAM_ADDR_W-1:0]   addr_in,
    input  wire logic [`SRAM_DATA_W-1:0]   wdata_in,
    input  wire logic                      powerfail_in,
    input  wire logic [`SRAM_DATA_W-1:0]   data_bus_io_in,
    output logic                           ready_out,
    output logic [`SRAM_DATA_W-1:0]        rdata_out,
    output logic                           rvalid_out,
    output logic                           wdone_out,
    output logic                           ce_n_out,
    output logic                           oe_n_out,
    output logic                           we_n_out,
    output logic [`SRAM_ADDR_W-1:0]        addr_lines_out,
    output logic [`SRAM_DATA_W-1:0]        data_bus_io_out,
    output logic                           data_bus_io_oe_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        sram_host_pkg::state_t    state;
        logic [15:0]              cnt;
        logic                     ready;
        logic                     ce_n;
        logic                     oe_n;
        logic                     we_n;
        logic [`SRAM_ADDR_W-1:0]  addr;
        logic [`SRAM_DATA_W-1:0]  dout;
        logic                     doe;
        logic [`SRAM_DATA_W-1:0]  rdata;
        logic                     rvalid;
        logic                     wdone;
        logic                     pf_s1;
        logic                     pf_s2;
        logic [`SRAM_DATA_W-1:0]  dq_s1;
        logic [`SRAM_DATA_W-1:0]  dq_s2;
    } regs_t;

    regs_t cur;
    regs_t next_cur;

    localparam logic [15:0] READ_LAST  = 16'(`SRAM_READ_CYC - 1);
    localparam logic [15:0] WP_LAST    = 16'(`SRAM_WPULSE_CYC - 1);
    localparam logic [15:0] DH_LAST    = 16'(`SRAM_DHOLD_CYC - 1);
    localparam logic [15:0] WREC_LAST  = 16'(`SRAM_WREC_CYC - 1);
    localparam logic [15:0] RREL_LAST  = 16'(`SRAM_RREL_CYC - 1);
    localparam logic [15:0] PREC_LAST  = 16'(RECOVERY_CYC - 1);

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    // every field but the rvalid and wdone pulses, the cnt down-count, ready and the synchroniser flops
    // defaults to its current value, so any path not listed leaves the strobes where they are
    always_comb begin
        next_cur        = cur;
        next_cur.rvalid = 1'b0;
        next_cur.wdone  = 1'b0;
        // pins pass two flops; only the second stage is looked at
        next_cur.pf_s1  = powerfail_in;
        next_cur.pf_s2  = cur.pf_s1;
        next_cur.dq_s1  = data_bus_io_in;
        next_cur.dq_s2  = cur.dq_s1;
        if (cur.cnt != 16'h0000) begin
            next_cur.cnt = cur.cnt - 16'h0001;
        end
        case (cur.state)
            sram_host_pkg::st_idle: begin
                if (req_in && !we_in) begin
                    // read access: select and gate low, strobe high
                    next_cur.addr  = addr_in;
                    next_cur.ce_n  = 1'b0;
                    next_cur.oe_n  = 1'b0;
                    next_cur.cnt   = READ_LAST;
                    next_cur.state = sram_host_pkg::st_read;
                end else if (req_in && we_in) begin
                    // select and strobe fall together, gate stays high
                    next_cur.addr  = addr_in;
                    next_cur.dout  = wdata_in;
                    next_cur.doe   = 1'b1;
                    next_cur.ce_n  = 1'b0;
                    next_cur.we_n  = 1'b0;
                    next_cur.cnt   = WP_LAST;
                    next_cur.state = sram_host_pkg::st_write;
                end
            end
            sram_host_pkg::st_read: begin
                // wait out access delay plus synchroniser
                if (cur.cnt == 16'h0000) begin
                    next_cur.rdata  = cur.dq_s2;
                    next_cur.rvalid = 1'b1;
                    next_cur.ce_n   = 1'b1;
                    next_cur.oe_n   = 1'b1;
                    next_cur.cnt    = RREL_LAST;
                    next_cur.state  = sram_host_pkg::st_turn;
                end
            end
            sram_host_pkg::st_write: begin
                // both strobes rise at once to store the byte
                if (cur.cnt == 16'h0000) begin
                    next_cur.ce_n  = 1'b1;
                    next_cur.we_n  = 1'b1;
                    next_cur.cnt   = DH_LAST;
                    next_cur.state = sram_host_pkg::st_whold;
                end
            end
            sram_host_pkg::st_whold: begin
                // data held past the ending edge
                if (cur.cnt == 16'h0000) begin
                    next_cur.doe   = 1'b0;
                    next_cur.wdone = 1'b1;
                    next_cur.cnt   = WREC_LAST;
                    next_cur.state = sram_host_pkg::st_turn;
                end
            end
            sram_host_pkg::st_turn: begin
                // strobes stay high for recovery before next access
                if (cur.cnt == 16'h0000) begin
                    next_cur.state = sram_host_pkg::st_idle;
                end
            end
            sram_host_pkg::st_pfail: begin
                // count recovery from the flag falling, restart if it rises
                if (cur.pf_s2) begin
                    next_cur.cnt = PREC_LAST;
                end else if (cur.cnt == 16'h0000) begin
                    next_cur.state = sram_host_pkg::st_idle;
                end
            end
            default: begin
                next_cur.state = sram_host_pkg::st_idle;
            end
        endcase
        // supply fail aborts any access at once; an aborted write
        // ends on the rising strobes, so only its own byte is at risk
        if (cur.pf_s2) begin
            next_cur.ce_n  = 1'b1;
            next_cur.oe_n  = 1'b1;
            next_cur.we_n  = 1'b1;
            next_cur.doe   = 1'b0;
            next_cur.cnt   = PREC_LAST;
            next_cur.state = sram_host_pkg::st_pfail;
        end
        next_cur.ready = (next_cur.state == sram_host_pkg::st_idle);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // reset lands in power-fail recovery, since supply state is unknown
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            cur       <= '0;
            cur.state <= sram_host_pkg::st_pfail;
            cur.cnt   <= PREC_LAST;
            cur.ce_n  <= 1'b1;
            cur.oe_n  <= 1'b1;
            cur.we_n  <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    // outputs straight from the state flops
    assign ready_out          = cur.ready;
    assign rdata_out          = cur.rdata;
    assign rvalid_out         = cur.rvalid;
    assign wdone_out          = cur.wdone;
    assign ce_n_out           = cur.ce_n;
    assign oe_n_out           = cur.oe_n;
    assign we_n_out           = cur.we_n;
    assign addr_lines_out     = cur.addr;
    assign data_bus_io_out    = cur.dout;
    assign data_bus_io_oe_out = cur.doe;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence write_pulse_s;
        (!we_n_out && !ce_n_out && oe_n_out && data_bus_io_oe_out) [*4];
    endsequence

    sequence write_end_s;
        we_n_out && ce_n_out && data_bus_io_oe_out && $stable(data_bus_io_out);
    endsequence

    // a supply fail may legally cut the pulse short, so it ends the attempt
    property write_shape_p;
        @(posedge clk_in) disable iff (!resetn_in || cur.pf_s2)
        $fell(we_n_out) |-> write_pulse_s ##1 write_end_s;
    endproperty

    write_shape_a: assert property (write_shape_p)
        else $error("write pulse shape wrong");

    gate_in_write_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !we_n_out |-> oe_n_out)
        else $error("output gate low during write");

    strobes_together_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        $fell(we_n_out) |-> $fell(ce_n_out))
        else $error("select and strobe did not fall together");

    addr_stable_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !ce_n_out && !$fell(ce_n_out) |-> $stable(addr_lines_out))
        else $error("address moved during access");

    data_stable_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !we_n_out && !$fell(we_n_out) |-> $stable(data_bus_io_out) && data_bus_io_oe_out)
        else $error("write data not stable");

    recovery_gap_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        $rose(ce_n_out) |-> ce_n_out [*2])
        else $error("no recovery between accesses");

    read_length_a: assert property (@(posedge clk_in) disable iff (!resetn_in || cur.pf_s2)
        $fell(oe_n_out) |-> !oe_n_out [*6] ##1 oe_n_out && rvalid_out)
        else $error("read held wrong number of cycles");

    pfail_deselect_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        $past(cur.pf_s2) |-> ce_n_out && we_n_out && oe_n_out && !data_bus_io_oe_out && !ready_out)
        else $error("access during power fail");

    // helper counter: cycles since the synced fail flag last fell
    logic [15:0] pf_quiet;
    always_ff @(posedge clk_in) begin
        if (!resetn_in || cur.pf_s2) begin
            pf_quiet <= 16'h0000;
        end else if (pf_quiet != 16'hffff) begin
            pf_quiet <= pf_quiet + 16'h0001;
        end
    end

    pfail_recover_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (cur.state == sram_host_pkg::st_pfail) && !cur.pf_s2 && (pf_quiet < PREC_LAST) |=> !ready_out)
        else $error("left power fail before recovery");

endmodule
`default_nettype wire

/* File: dv/sram_device_model.sv */
// behavioural model of the byte-wide static ram on the far side of the port
`default_nettype none
module sram_device_model #(
    parameter int ACC_CYC = 2,
    parameter int REC_CYC = 4
) (
    input  wire logic        clk_in,
    input  wire logic        ce_n_in,
    input  wire logic        oe_n_in,
    input  wire logic        we_n_in,
    input  wire logic [14:0] addr_in,
    input  wire logic [7:0]  host_data_in,
    input  wire logic        host_oe_in,
    input  wire logic        powerfail_in,
    output logic      [7:0]  bus_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------
    // storage and mode decode
    // ------------------------------------------------
    // one byte per address
    logic [7:0]  mem [0:32767];
    logic [16:0] prev;
    logic        wr_prev = 1'b0;
    int          acc = 0;
    int          rec = 0;
    logic [7:0]  idle_pat = 8'h55;
    logic        active;
    logic        wr_now;
    logic        drive;
    assign active = !powerfail_in && rec == 0;
    assign wr_now = active && !ce_n_in && !we_n_in;
    assign drive = active && !ce_n_in && !oe_n_in && we_n_in;
    // junk until access time; floating bus toggles so stale values never pass
    always_comb begin
        bus_out = host_oe_in ? host_data_in : drive ? (acc >= ACC_CYC ? mem[addr_in] : ~mem[addr_in]) : idle_pat;
    end
    // access timer, recovery timer and write capture
    always @(posedge clk_in) begin
        idle_pat <= ~idle_pat;
        acc <= ({ce_n_in, oe_n_in, addr_in} != prev) ? 0 : acc + 1;
        prev <= {ce_n_in, oe_n_in, addr_in};
        rec <= powerfail_in ? REC_CYC : (rec > 0 ? rec - 1 : 0);
        wr_prev <= wr_now;
        // store at the ending edge, aborted write lost
        if (wr_prev && !wr_now && active) begin
            mem[addr_in] <= host_data_in;
        end
    end
endmodule
`default_nettype wire

/* File: dv/async_sram_access_port_test.sv */
// self-checking bench for the static ram access port controller
`default_nettype none
module async_sram_access_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int REC = 12;
    typedef struct packed {logic we; logic [14:0] addr; logic [7:0] data;} row_t;
    logic        clk_in = 1'b0;
    logic        resetn_in = 1'b0;
    logic        req_in = 1'b0;
    logic        we_in = 1'b0;
    logic        powerfail_in = 1'b0;
    logic [14:0] addr_in = 15'h0000;
    logic [7:0]  wdata_in = 8'h00;
    logic [7:0]  bus;
    logic        ready_out, rvalid_out, wdone_out, ce_n_out, oe_n_out, we_n_out, bus_oe;
    logic [7:0]  rdata_out, bus_drv;
    logic [14:0] addr_lines_out;
    int          err_count = 0;
    int          samples_checked = 0;
    row_t        rows [8] = '{'{1'b1, 15'h0000, 8'ha5}, '{1'b1, 15'h7fff, 8'h3c}, '{1'b1, 15'h0101, 8'h22},
                              '{1'b0, 15'h0000, 8'ha5}, '{1'b0, 15'h7fff, 8'h3c}, '{1'b0, 15'h0101, 8'h22},
                              '{1'b1, 15'h0000, 8'h5a}, '{1'b0, 15'h0000, 8'h5a}};
    // ------------------------------------------------
    // clock, design and far side
    // ------------------------------------------------
    always #12.5 clk_in = ~clk_in;
    async_sram_access_port #(.RECOVERY_CYC(REC)) dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .req_in(req_in),
        .we_in(we_in), .addr_in(addr_in), .wdata_in(wdata_in), .powerfail_in(powerfail_in),
        .data_bus_io_in(bus), .ready_out(ready_out), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
        .wdone_out(wdone_out), .ce_n_out(ce_n_out), .oe_n_out(oe_n_out), .we_n_out(we_n_out),
        .addr_lines_out(addr_lines_out), .data_bus_io_out(bus_drv), .data_bus_io_oe_out(bus_oe));
    sram_device_model #(.ACC_CYC(2), .REC_CYC(4)) ram_u (.clk_in(clk_in), .ce_n_in(ce_n_out),
        .oe_n_in(oe_n_out), .we_n_in(we_n_out), .addr_in(addr_lines_out), .host_data_in(bus_drv),
        .host_oe_in(bus_oe), .powerfail_in(powerfail_in), .bus_out(bus));
    // ------------------------------------------------
    // compare, report and bus tasks
    // ------------------------------------------------
    task automatic check8(input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic check15(input logic [14:0] exp, input logic [14:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic check1(input logic exp, input logic got);
        check8({7'h00, exp}, {7'h00, got});
    endtask
    task automatic wrap_up;
        $display("errors %0d comparisons %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // request held until taken, then wait for the completion pulse
    task automatic do_op(input logic we, input logic [14:0] a, input logic [7:0] d,
                         output logic [7:0] rd, output int waited);
        int n;
        req_in <= 1'b1;
        we_in <= we;
        addr_in <= a;
        wdata_in <= d;
        waited = 0;
        do begin @(posedge clk_in); waited++; end while (ready_out !== 1'b1 && waited < 200);
        req_in <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
            // first cycle of the access: pins carry what was asked for
            if (n == 1) begin
                check15(a, addr_lines_out);
                check1(we, oe_n_out);
                if (we) check8(d, bus_drv);
            end
        end while (rvalid_out !== 1'b1 && wdone_out !== 1'b1 && n < 20);
        check8(we ? 8'h06 : 8'h07, 8'(n));
        rd = rdata_out;
    endtask
    // write strobe only with select low and output gate high
    always @(posedge clk_in) begin
        if (resetn_in && we_n_out === 1'b0) begin
            check1(1'b1, oe_n_out);
            check1(1'b0, ce_n_out);
        end
    end
    // ------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------
    initial begin
        logic [7:0] rd;
        int         w;
        logic       seen;
        repeat (3) @(posedge clk_in);
        resetn_in <= 1'b1;
        @(posedge clk_in);
        check1(1'b1, ce_n_out);
        check1(1'b0, bus_oe);
        check1(1'b0, ready_out);
        foreach (rows[i]) begin
            do_op(rows[i].we, rows[i].addr, rows[i].data, rd, w);
            if (!rows[i].we) check8(rows[i].data, rd);
        end
        // supply fails in mid-write: only the addressed byte may suffer
        req_in <= 1'b1;
        we_in <= 1'b1;
        addr_in <= 15'h0100;
        wdata_in <= 8'h11;
        do @(posedge clk_in); while (ready_out !== 1'b1);
        req_in <= 1'b0;
        powerfail_in <= 1'b1;
        seen = 1'b0;
        repeat (6) begin @(posedge clk_in); seen |= wdone_out; end
        check1(1'b1, we_n_out);
        check1(1'b1, ce_n_out);
        check1(1'b0, bus_oe);
        check1(1'b0, seen);
        check1(1'b0, ready_out);
        powerfail_in <= 1'b0;
        do_op(1'b0, 15'h0101, 8'h00, rd, w);
        check8(8'h22, rd);
        check1(1'b1, w > REC);
        check1(1'b1, w <= REC + 4);
        do_op(1'b1, 15'h0100, 8'h77, rd, w);
        do_op(1'b0, 15'h0100, 8'h00, rd, w);
        check8(8'h77, rd);
        // reset in mid-read: pins let go at once, stored bytes survive
        req_in <= 1'b1;
        we_in <= 1'b0;
        addr_in <= 15'h0101;
        do @(posedge clk_in); while (ready_out !== 1'b1);
        req_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        resetn_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        check1(1'b1, ce_n_out);
        check1(1'b1, oe_n_out);
        check1(1'b0, ready_out);
        resetn_in <= 1'b1;
        do_op(1'b0, 15'h0101, 8'h00, rd, w);
        check8(8'h22, rd);
        wrap_up();
    end
    initial begin
        repeat (3000) @(posedge clk_in);
        err_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
